// ===== src/syspin_pkg.sv
// Purpose: shared constants and carriers for the system pin control block
// Assumes: one clock domain, all pins sampled synchronously
// Notes:   clock select sits at bit 14 of the system control word
`default_nettype none
package syspin_pkg;
	localparam logic [15:0] PC_RESET_VALUE   = 16'h0000;
	localparam int          CLK_SEL_BIT      = 14;
	localparam logic [15:0] SYS_CTRL_RESET   = 16'h0000;
	localparam int          WD_PULSE_CYCLES  = 4;
	localparam int          PWM_WIDTH        = 8;
	localparam logic [2:0]  GPIO_DIR_RESET   = 3'h0;

	// sampled pin levels
	typedef struct packed {
		logic reset_n;
		logic protect_a_n;
		logic protect_b_n;
		logic irq_1;
		logic irq_2;
	} pin_sample_s;

	// software controls
	typedef struct packed {
		logic       irq1_rising;
		logic       irq2_rising;
		logic       irq1_gpio_sel;
		logic       irq2_gpio_sel;
		logic       cpu_clock_out_gpio_sel;
		logic [2:0] gpio_dir;
		logic [2:0] gpio_out;
	} pin_ctrl_s;
endpackage
`default_nettype wire

// ===== src/edge_catch.sv
// Purpose: two-flop synchroniser, edge detector and sticky pending flag
// Assumes: input asynchronous to ref_clk_i
// Notes:   set wins over a clear in the same cycle
`default_nettype none
module edge_catch
	import syspin_pkg::*;
(
	// clock and reset
	input  wire logic ref_clk_i,
	input  wire logic sys_rst_i,
	// pin side
	input  wire logic pin_i,
	input  wire logic rising_i,
	input  wire logic clear_i,
	// results
	output logic      level_o,
	output logic      edge_o,
	output logic      pend_o
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
		logic edg;
		logic pend;
	} ec_state_s;

	ec_state_s s_q;
	ec_state_s s_d;
	logic      hit;

	always_comb
	begin
		s_d      = s_q;
		s_d.meta = pin_i;
		s_d.sync = s_q.meta;
		s_d.prev = s_q.sync;
		hit      = rising_i ? (s_q.sync & ~s_q.prev) : (~s_q.sync & s_q.prev);
		s_d.edg  = hit;
		if (clear_i)
		begin
			s_d.pend = 1'b0;
		end
		if (hit)
		begin
			s_d.pend = 1'b1;
		end
	end

	// idle-high reset value so a high pin after reset is not taken as an edge
	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			s_q <= '{meta: 1'b1, sync: 1'b1, prev: 1'b1, edg: 1'b0, pend: 1'b0};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign level_o = s_q.sync;
	assign edge_o  = s_q.edg;
	assign pend_o  = s_q.pend;
endmodule
`default_nettype wire

// ===== src/syspin_ctrl.sv
// Purpose: system pin control: reset pin, drive protection, user irqs, clock out
// Assumes: all pins sampled on ref_clk_i (20 MHz), one clock domain
// Notes:   core execution modelled by a run flag and program counter only
//
// Functional notes
// [RL1] reset pin low halts execution, counter held at 0; restart from zero
// [RL2] device reset returns control and status state to reset values; code does this on sys_rst_i only, reset pin low clears only run and pc
// [RL3] watchdog overflow makes a reset pulse driven onto the reset pin
// [RL4] falling edge on protect a raises irq and floats unit a pwm
// [RL5] falling edge on protect b raises irq and floats unit b pwm
// [RL6] both user irqs edge triggered, edge selected by software
// [RL7] user irq 1 pin shares with a general-purpose io bit
// [RL8] user irq 2 also triggers adc conversion, or is general-purpose io
// [RL9] clock out carries cpu or watchdog clock by select bit 14
// [RL10] clock out pin is general-purpose io when not used as clock
// [RL11] all general-purpose io pins are inputs after any reset; code forces this on sys_rst_i only, not on reset pin low
// [RL12] inputs synchronised; each edge sets a pending flag held until serviced
`default_nettype none
module syspin_ctrl
	import syspin_pkg::*;
#(
	parameter int PWM_W = PWM_WIDTH
)
(
	// clock and reset
	input  wire logic             ref_clk_i,
	input  wire logic             sys_rst_i,
	// reset pin, open drain
	input  wire logic             device_reset_n_i,
	output logic                  device_reset_n_o,
	output logic                  device_reset_n_oe_n_o,
	input  wire logic             wd_overflow_i,
	// core
	output logic                  core_run_o,
	output logic [15:0]           program_counter_o,
	input  wire logic             pc_advance_i,
	// drive protection and pwm
	input  wire logic             drive_protect_a_n_i,
	input  wire logic             drive_protect_b_n_i,
	output logic                  event_manager_a_pwm_oe_n_o,
	output logic                  event_manager_b_pwm_oe_n_o,
	// user irq pins
	input  wire logic             user_irq_1_i,
	input  wire logic             user_irq_2_i,
	output logic                  gpio_port_a_bit2_o,
	output logic                  gpio_port_a_bit2_oe_n_o,
	output logic                  gpio_port_d_bit0_o,
	output logic                  gpio_port_d_bit0_oe_n_o,
	output logic                  adc_conv_trigger_o,
	// clock out pin
	input  wire logic             watchdog_clock_i,
	input  wire logic [15:0]      system_ctrl_status_i,
	output logic                  cpu_clock_out_o,
	output logic                  gpio_port_e_bit0_oe_n_o,
	// software control and status
	input  wire pin_ctrl_s        ctrl_i,
	input  wire logic [3:0]       pend_clear_i,
	output logic [3:0]            pend_o,
	output logic [2:0]            gpio_in_o
);
	typedef struct packed {
		logic        run;
		logic [15:0] pc;
		logic [2:0]  wd_cnt;
		logic        rst_drive;
		logic        float_a;
		logic        float_b;
		logic        adc_trig;
		logic        clk_out;
		logic [2:0]  oe_n;
		logic [2:0]  dout;
		logic [3:0]  pend;
		logic [2:0]  gin;
	} top_state_s;

	top_state_s s_q;
	top_state_s s_d;
	logic [3:0] edg;
	logic [3:0] lvl;
	logic [3:0] pnd;
	logic       pin_rst;

	////////////////////////////////////////////////////////////////////////
	// edge catchers: protect a, protect b, user irq 1, user irq 2
	edge_catch u_prot_a (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .pin_i(drive_protect_a_n_i),
		.rising_i(1'b0), .clear_i(pend_clear_i[0]), .level_o(lvl[0]), .edge_o(edg[0]), .pend_o(pnd[0])); // RL12
	edge_catch u_prot_b (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .pin_i(drive_protect_b_n_i),
		.rising_i(1'b0), .clear_i(pend_clear_i[1]), .level_o(lvl[1]), .edge_o(edg[1]), .pend_o(pnd[1])); // RL12
	edge_catch u_irq_1 (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .pin_i(user_irq_1_i),
		.rising_i(ctrl_i.irq1_rising), .clear_i(pend_clear_i[2]), .level_o(lvl[2]), .edge_o(edg[2]),
		.pend_o(pnd[2])); // RL6
	edge_catch u_irq_2 (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .pin_i(user_irq_2_i),
		.rising_i(ctrl_i.irq2_rising), .clear_i(pend_clear_i[3]), .level_o(lvl[3]), .edge_o(edg[3]),
		.pend_o(pnd[3])); // RL6

	// reset pin level goes through the same synchroniser style
	logic rst_meta_q;
	logic rst_sync_q;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= device_reset_n_i;
			rst_sync_q <= rst_meta_q;
		end
	end
	assign pin_rst = ~rst_sync_q;

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		s_d      = s_q;
		s_d.pend = pnd;
		s_d.gin  = {lvl[3], lvl[2], watchdog_clock_i};
		// watchdog pulse of fixed length onto the open-drain pin
		if (wd_overflow_i)
		begin
			s_d.wd_cnt    = 3'(WD_PULSE_CYCLES); // RL3
			s_d.rst_drive = 1'b1;
		end
		else if (s_q.wd_cnt != 3'h0)
		begin
			s_d.wd_cnt    = s_q.wd_cnt - 3'h1;
			s_d.rst_drive = (s_q.wd_cnt != 3'h1); // RL3
		end
		// latched float holds until software clears the pending flag
		if (edg[0])
		begin
			s_d.float_a = 1'b1; // RL4
		end
		else if (!pnd[0])
		begin
			s_d.float_a = 1'b0;
		end
		if (edg[1])
		begin
			s_d.float_b = 1'b1; // RL5
		end
		else if (!pnd[1])
		begin
			s_d.float_b = 1'b0;
		end
		s_d.adc_trig = edg[3] & ~ctrl_i.irq2_gpio_sel; // RL8
		// watchdog clock is sampled, so its rate must be well below ref_clk_i
		s_d.clk_out  = system_ctrl_status_i[CLK_SEL_BIT] ? watchdog_clock_i : ~s_q.clk_out; // RL9
		if (ctrl_i.cpu_clock_out_gpio_sel)
		begin
			s_d.clk_out = ctrl_i.gpio_out[2]; // RL10
		end
		s_d.oe_n[0] = ~(ctrl_i.irq1_gpio_sel & ctrl_i.gpio_dir[0]); // RL7
		s_d.oe_n[1] = ~(ctrl_i.irq2_gpio_sel & ctrl_i.gpio_dir[1]); // RL8
		s_d.oe_n[2] = ctrl_i.cpu_clock_out_gpio_sel & ~ctrl_i.gpio_dir[2]; // RL10
		s_d.dout    = ctrl_i.gpio_out;
		s_d.run     = 1'b1;
		if (s_q.run && pc_advance_i)
		begin
			s_d.pc = s_q.pc + 16'h0001;
		end
		if (pin_rst)
		begin
			s_d.run = 1'b0; // RL1
			s_d.pc  = PC_RESET_VALUE; // RL1
		end
	end

	// every control field returns to a constant under reset
	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			s_q         <= '0; // RL2
			s_q.oe_n    <= ~GPIO_DIR_RESET; // RL11
			s_q.pc      <= PC_RESET_VALUE;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign device_reset_n_o           = 1'b0;
	assign device_reset_n_oe_n_o      = ~s_q.rst_drive;
	assign core_run_o                 = s_q.run;
	assign program_counter_o          = s_q.pc;
	assign event_manager_a_pwm_oe_n_o = s_q.float_a;
	assign event_manager_b_pwm_oe_n_o = s_q.float_b;
	assign gpio_port_a_bit2_o         = s_q.dout[0];
	assign gpio_port_a_bit2_oe_n_o    = s_q.oe_n[0];
	assign gpio_port_d_bit0_o         = s_q.dout[1];
	assign gpio_port_d_bit0_oe_n_o    = s_q.oe_n[1];
	assign adc_conv_trigger_o         = s_q.adc_trig;
	assign cpu_clock_out_o            = s_q.clk_out;
	assign gpio_port_e_bit0_oe_n_o    = s_q.oe_n[2];
	assign pend_o                     = s_q.pend;
	assign gpio_in_o                  = s_q.gin;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	pc_held_zero_a: assert property (pin_rst |=> program_counter_o == 16'h0000 && !core_run_o) // RL1
		else $error("counter not held at zero in reset");
	wd_pulse_len_a: assert property ($rose(wd_overflow_i) && !s_q.rst_drive |=> !device_reset_n_oe_n_o [*4]) // RL3
		else $error("watchdog reset pulse too short");
	float_a_on_a: assert property (edg[0] |=> event_manager_a_pwm_oe_n_o) // RL4
		else $error("unit a pwm not floated");
	float_b_on_a: assert property (edg[1] |=> event_manager_b_pwm_oe_n_o) // RL5
		else $error("unit b pwm not floated");
	irq_pend_set_a: assert property (edg[2] |=> pend_o[2]) // RL6
		else $error("irq 1 edge not pending");
	irq1_gpio_in_a: assert property (!ctrl_i.irq1_gpio_sel |=> gpio_port_a_bit2_oe_n_o) // RL7
		else $error("irq 1 pin driven while irq");
	adc_trig_a: assert property (edg[3] && !ctrl_i.irq2_gpio_sel |=> adc_conv_trigger_o) // RL8
		else $error("adc trigger missing");
	clk_sel_a: assert property (system_ctrl_status_i[CLK_SEL_BIT] && !ctrl_i.cpu_clock_out_gpio_sel
		|=> cpu_clock_out_o == $past(watchdog_clock_i)) // RL9
		else $error("clock out not watchdog clock");
	cpu_clock_out_gpio_a: assert property (ctrl_i.cpu_clock_out_gpio_sel |=> cpu_clock_out_o == $past(ctrl_i.gpio_out[2])) // RL10
		else $error("clock pin not gpio");
	// pend_o lags the catcher by one cycle, so the clear that matters is the previous one
	pend_hold_a: assert property (pend_o[0] && !$past(pend_clear_i[0]) |=> pend_o[0]) // RL12
		else $error("pending flag lost");

	wd_pulse_c: cover property (wd_overflow_i ##1 !device_reset_n_oe_n_o);
	prot_a_c: cover property (edg[0] ##1 event_manager_a_pwm_oe_n_o);
	adc_c: cover property (adc_conv_trigger_o);
endmodule
`default_nettype wire

// ===== verif/board_model.sv
// Purpose: board side of the system pins: reset pin pull-up and watchdog clock
// Assumes: reset pin is open drain with a pull-up on the board
// Notes:   watchdog clock runs free at ref_clk/8
`default_nettype none
module board_model
	import syspin_pkg::*;
(
	// clock
	input  wire logic ref_clk_i,
	// reset pin
	input  wire logic ext_reset_n_i,
	input  wire logic reset_data_i,
	input  wire logic reset_oe_n_i,
	output logic      device_reset_n_o,
	// watchdog clock
	output logic      watchdog_clock_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] div_q = 3'h0;
	// wired-and: either party pulling low wins, pull-up otherwise
	assign device_reset_n_o = ext_reset_n_i & (reset_oe_n_i | reset_data_i);
	assign watchdog_clock_o = div_q[2];
	always @(posedge ref_clk_i)
		div_q <= div_q + 3'h1;
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Purpose: self-checking bench for the system pin control block
// Assumes: board model supplies reset pin level and watchdog clock
// Notes:   inputs change 1ns after the rising edge
`default_nettype none
module tb_top
	import syspin_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk_i = 0;
	logic        sys_rst_i = 1;
	logic        ext_n = 1;
	logic        wd_ovf = 0;
	logic [1:0]  prot_n = 2'h3;
	logic [1:0]  irq = 2'h3;
	logic [3:0]  clr = 4'h0;
	logic [15:0] sctl = 16'h0000;
	pin_ctrl_s   ctrl = '0;
	logic        rst_pin, rst_o, rst_oe_n, run, watchdog_clock, pa, pb, a2, a2_oe, d0, d0_oe, adc, clko, e0_oe;
	logic [15:0] pc;
	logic [3:0]  pend;
	logic [2:0]  gin;
	int          fails = 0;
	int          comparisons = 0;

	always #25 ref_clk_i = ~ref_clk_i;

	board_model i_board (.ref_clk_i(ref_clk_i), .ext_reset_n_i(ext_n), .reset_data_i(rst_o),
		.reset_oe_n_i(rst_oe_n), .device_reset_n_o(rst_pin), .watchdog_clock_o(watchdog_clock));

	syspin_ctrl i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .device_reset_n_i(rst_pin),
		.device_reset_n_o(rst_o), .device_reset_n_oe_n_o(rst_oe_n), .wd_overflow_i(wd_ovf),
		.core_run_o(run), .program_counter_o(pc), .pc_advance_i(1'b1),
		.drive_protect_a_n_i(prot_n[0]), .drive_protect_b_n_i(prot_n[1]),
		.event_manager_a_pwm_oe_n_o(pa), .event_manager_b_pwm_oe_n_o(pb),
		.user_irq_1_i(irq[0]), .user_irq_2_i(irq[1]), .gpio_port_a_bit2_o(a2),
		.gpio_port_a_bit2_oe_n_o(a2_oe), .gpio_port_d_bit0_o(d0), .gpio_port_d_bit0_oe_n_o(d0_oe),
		.adc_conv_trigger_o(adc), .watchdog_clock_i(watchdog_clock), .system_ctrl_status_i(sctl),
		.cpu_clock_out_o(clko), .gpio_port_e_bit0_oe_n_o(e0_oe), .ctrl_i(ctrl),
		.pend_clear_i(clr), .pend_o(pend), .gpio_in_o(gin));

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wait_pend(input int b);
		for (int i = 0; i < 8 && pend[b] !== 1'b1; i++)
			cyc(1);
	endtask

	task automatic clear_all;
		clr = 4'hf;
		cyc(1);
		clr = 4'h0;
		cyc(3);
	endtask

	// falling edge floats the owning unit until serviced
	task automatic t_prot(input int b);
		prot_n[b] = 1'b0;
		wait_pend(b);
		chk(pend[b], 1'b1);
		chk({pb, pa}, 2'h1 << b);
		prot_n[b] = 1'b1;
		cyc(6);
		chk(pend[b], 1'b1);
		clear_all();
		chk({pend[b], pb, pa}, 3'h0);
	endtask

	// irq1 on rising only; irq2 on falling, with and without adc trigger
	task automatic t_irq;
		int n;
		ctrl.irq1_rising = 1'b1;
		irq[0] = 1'b0;
		cyc(8);
		chk(pend[2], 1'b0);
		chk(gin[2:1], 2'h2);
		irq[0] = 1'b1;
		wait_pend(2);
		chk(pend[2], 1'b1);
		for (int g = 0; g < 2; g++)
		begin
			n = 0;
			ctrl.irq2_gpio_sel = g[0];
			irq[1] = 1'b0;
			for (int i = 0; i < 8; i++)
			begin
				cyc(1);
				n += (adc === 1'b1);
			end
			chk(n, g ? 0 : 1);
			chk(pend[3], 1'b1);
			irq[1] = 1'b1;
			cyc(6);
			clear_all();
		end
	endtask

	// watchdog pulse on the reset pin halts the core and restarts it from zero
	task automatic t_wd;
		int lo = 0;
		int stop = 0;
		int go = 0;
		wd_ovf = 1'b1;
		cyc(1);
		wd_ovf = 1'b0;
		for (int i = 0; i < 12; i++)
		begin
			lo += (rst_oe_n === 1'b0);
			if (run === 1'b0)
			begin
				stop++;
				chk(pc, PC_RESET_VALUE);
			end
			else if (stop > 0)
			begin
				go++;
			end
			cyc(1);
		end
		chk(lo, WD_PULSE_CYCLES);
		chk(stop > 0, 1'b1);
		chk(run, 1'b1);
		// one advance per running cycle, counted from zero after the restart
		chk(pc, go);
	endtask

	// toggle count of the clock pin over 64 cycles, ranged for sync slip
	task automatic count_clk(input int lo, input int hi);
		int t = 0;
		logic p;
		p = clko;
		for (int i = 0; i < 64; i++)
		begin
			cyc(1);
			t += (clko !== p);
			p = clko;
		end
		chk(t >= lo && t <= hi, 1'b1);
	endtask

	task automatic t_clk_gpio;
		chk(e0_oe, 1'b0);
		count_clk(62, 64);
		sctl[CLK_SEL_BIT] = 1'b1;
		count_clk(14, 18);
		ctrl.cpu_clock_out_gpio_sel = 1'b1;
		ctrl.irq1_gpio_sel = 1'b1;
		ctrl.irq2_gpio_sel = 1'b1;
		ctrl.gpio_dir = 3'h3;
		ctrl.gpio_out = 3'h1;
		cyc(3);
		chk({e0_oe, a2_oe, a2, d0_oe, d0}, 5'h14);
		ctrl.gpio_dir = 3'h7;
		ctrl.gpio_out = 3'h4;
		cyc(2);
		chk({e0_oe, clko}, 2'h1);
	endtask

	// mid-run reset with pins driven and a flag pending
	task automatic t_rst;
		prot_n[0] = 1'b0;
		wait_pend(0);
		chk(pend[0], 1'b1);
		sys_rst_i = 1'b1;
		prot_n[0] = 1'b1;
		cyc(2);
		chk({a2_oe, d0_oe, e0_oe, pa, pb, pend, run, pc}, {3'h7, 23'h0});
		sys_rst_i = 1'b0;
		cyc(4);
		chk({run, pend}, 5'h10);
	endtask

	task automatic final_report;
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		#100us;
		fails++;
		final_report();
	end

	initial
	begin
		cyc(5);
		chk({a2_oe, d0_oe, e0_oe, pa, pb, pend, run, pc}, {3'h7, 23'h0});
		sys_rst_i = 1'b0;
		cyc(6);
		chk(run, 1'b1);
		t_prot(0);
		t_prot(1);
		t_irq();
		t_wd();
		t_clk_gpio();
		t_rst();
		final_report();
	end
endmodule
`default_nettype wire
